/* hw/asrc_host.sv */
// Host controller that reads and writes a 64K by 1 asynchronous static RAM
`timescale 1ns/1ps
module asrc_host
  import asrc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // User request
  input  wire logic       req_valid_in,
  output logic            req_ready_out,
  input  wire asrc_req_t  req_in,
  // Read answer
  output logic            rd_valid_out,
  output logic            rd_data_out,
  // RAM pins
  output asrc_pins_t      ram_pins_out,
  input  wire logic       ram_data_out_in
);

  // ==========================================================
  // Elaboration checks
  // Refuse timing counts that the wait counter cannot reach
  if ((ACCESS_CYC + 2) >= (1 << CNT_W) || WPULSE_CYC >= (1 << CNT_W) ||
      FLOAT_CYC >= (1 << CNT_W) || CYCLE_CYC >= (1 << CNT_W)) begin : g_bad_timing
    $error("Timing counts exceed counter width");
  end

  // ==========================================================
  // Read data synchroniser
  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;

  // Two stages on the RAM output pin
  always_comb begin
    sync1_next = ram_data_out_in;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ==========================================================
  // Sequencer
  asrc_state_t       state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              wdata_reg, wdata_next;
  logic              sel_n_reg, sel_n_next;
  logic              wr_n_reg, wr_n_next;
  logic              rdv_reg, rdv_next;
  logic              rdd_reg, rdd_next;

  assign req_ready_out = (state_reg == ST_IDLE);

  // Next state and pin values
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    sel_n_next = sel_n_reg;
    wr_n_next  = wr_n_reg;
    rdv_next   = 1'h0;
    rdd_next   = rdd_reg;
    case (state_reg)
      ST_IDLE: begin
        // Address changes only here, with select and strobe high
        if (req_valid_in) begin
          addr_next  = req_in.addr;
          wdata_next = req_in.wdata;
          cnt_next   = '0;
          if (req_in.write) begin
            // Select and strobe fall together one cycle after address
            state_next = ST_WPULSE;
          end else begin
            state_next = ST_RSETUP;
          end
        end
      end
      ST_RSETUP: begin
        // Select low, strobe high: read mode
        sel_n_next = 1'h0;
        wr_n_next  = 1'h1;
        cnt_next   = '0;
        state_next = ST_RWAIT;
      end
      ST_RWAIT: begin
        // Wait access delay from select, plus synchroniser
        cnt_next = cnt_reg + 1'h1;
        if (cnt_reg == CNT_W'(ACCESS_CYC + 2)) begin
          rdv_next   = 1'h1;
          rdd_next   = sync2_reg;
          sel_n_next = 1'h1;
          cnt_next   = '0;
          state_next = ST_RECOV;
        end
      end
      ST_WPULSE: begin
        // Address and data held for the whole pulse
        sel_n_next = 1'h0;
        wr_n_next  = 1'h0;
        cnt_next   = cnt_reg + 1'h1;
        if (cnt_reg == CNT_W'(WPULSE_CYC)) begin
          // End write by raising strobe and select together
          sel_n_next = 1'h1;
          wr_n_next  = 1'h1;
          cnt_next   = '0;
          state_next = ST_RECOV;
        end
      end
      ST_RECOV: begin
        // Deselected standby for float time, counted from FLOAT_CYC but at least one
        cnt_next = cnt_reg + 1'h1;
        if (cnt_reg == CNT_W'(((FLOAT_CYC > 1) ? FLOAT_CYC : 1))) begin
          cnt_next   = '0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        sel_n_next = 1'h1;
        wr_n_next  = 1'h1;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      addr_reg  <= '0;
      wdata_reg <= 1'h0;
      sel_n_reg <= SEL_N_RST;   // Standby from reset
      wr_n_reg  <= WR_N_RST;
      rdv_reg   <= 1'h0;
      rdd_reg   <= 1'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      sel_n_reg <= sel_n_next;
      wr_n_reg  <= wr_n_next;
      rdv_reg   <= rdv_next;
      rdd_reg   <= rdd_next;
    end
  end

  // Output drive
  assign ram_pins_out.location_select_lines = addr_reg;
  assign ram_pins_out.sel_n                 = sel_n_reg;
  assign ram_pins_out.wr_strobe_n           = wr_n_reg;
  assign ram_pins_out.data_in               = wdata_reg;
  assign rd_valid_out                       = rdv_reg;
  assign rd_data_out                        = rdd_reg;

  // ==========================================================
  // Assertions
  sequence s_write_pulse;
    !sel_n_reg && !wr_n_reg;
  endsequence

  a_addr_change_safe: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $changed(addr_reg) |-> $past(sel_n_reg) && sel_n_reg)
    else $error("Address changed while selected");

  a_addr_write_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!wr_n_reg && $past(!wr_n_reg)) |-> $stable(addr_reg))
    else $error("Address moved during write");

  a_data_write_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!wr_n_reg && $past(!wr_n_reg)) |-> $stable(wdata_reg))
    else $error("Data moved during write");

  a_write_width: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $fell(wr_n_reg) |-> s_write_pulse [*4])
    else $error("Write pulse too short");

  a_write_ends: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $fell(wr_n_reg) |-> ##[4:6] wr_n_reg && sel_n_reg)
    else $error("Write did not end in time");

  a_read_strobe_high: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == ST_RWAIT) |-> !sel_n_reg && wr_n_reg)
    else $error("Read without read mode pins");

  a_read_latency: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $rose(rdv_reg) |-> $past(!sel_n_reg, 8))
    else $error("Read sampled before access delay");

  a_ready_standby: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    req_ready_out |-> sel_n_reg && wr_n_reg)
    else $error("Idle while selected");

  a_recovery_gap: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $rose(sel_n_reg) |-> sel_n_reg [*2])
    else $error("Reselected before output floats");

endmodule

/* pkg/asrc_pkg.sv */
// Constants, states and carrier types for the async static RAM host controller
package asrc_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 16;
  localparam int DEPTH  = 65536;

  // ==========================================================
  // Timing, 45 ns speed grade, clock 100 MHz
  localparam int CLK_PERIOD_NS     = 10;
  localparam int ADDR_ACCESS_NS    = 45;  // Address and select access, max
  localparam int WRITE_PULSE_NS    = 40;  // Select and strobe to end of write, min
  localparam int DATA_SETUP_NS     = 35;  // Data valid before end of write, min
  localparam int FLOAT_NS          = 15;  // Strobe or select to float, max
  localparam int CYCLE_NS          = 45;  // Read and write cycle, min
  // Least times round up
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYC = (((WRITE_PULSE_NS > DATA_SETUP_NS) ? WRITE_PULSE_NS : DATA_SETUP_NS)
                               + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC  = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC  = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 4;

  // ==========================================================
  // Reset values of the pins
  localparam logic SEL_N_RST = 1'h1;
  localparam logic WR_N_RST  = 1'h1;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_RSETUP = 5'h02,
    ST_RWAIT  = 5'h04,
    ST_WPULSE = 5'h08,
    ST_RECOV  = 5'h10
  } asrc_state_t;

  // ==========================================================
  // Pins toward the RAM
  typedef struct packed {
    logic [ADDR_W-1:0] location_select_lines;
    logic              sel_n;
    logic              wr_strobe_n;
    logic              data_in;
  } asrc_pins_t;

  // User request
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } asrc_req_t;

endpackage

/* tb/asrc_host_tb_top.sv */
// Self-checking bench for the async static RAM host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); mismatches++; end end
module asrc_host_tb_top import asrc_pkg::*;;
  logic       clk_sys_in   = 1'h0;
  logic       rstn_in      = 1'h0;
  logic       req_valid_in = 1'h0;
  asrc_req_t  req_in       = '0;
  logic       req_ready_out;
  logic       rd_valid_out;
  logic       rd_data_out;
  asrc_pins_t ram_pins_out;
  logic       ram_data_out_in;
  int         mismatches   = 0;
  int         num_checks   = 0;

  // ==========================================================
  // Clock, design and RAM model
  always #5 clk_sys_in = ~clk_sys_in;
  asrc_host DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .ram_pins_out(ram_pins_out), .ram_data_out_in(ram_data_out_in));
  asrc_ram_model u_ram (.pins_in(ram_pins_out), .q_out(ram_data_out_in));

  // ==========================================================
  // Verdict and exit
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One request, judging pin sequence and answer timing
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic d, output logic q);
    int n, lo, vc;
    n = 0; lo = 0; vc = 0; q = 1'h0;
    `CHK("ready", 1'h1, req_ready_out)
    req_valid_in = 1'h1;
    req_in = '{write: wr, addr: a, wdata: d};
    @(posedge clk_sys_in); #1;
    req_valid_in = 1'h0;
    while (req_ready_out !== 1'h1) begin
      @(posedge clk_sys_in); #1;
      n++;
      if (ram_pins_out.sel_n === 1'h0) begin
        lo++;
        `CHK("strobe", ~wr, ram_pins_out.wr_strobe_n)
        `CHK("address", a, ram_pins_out.location_select_lines)
        if (wr) `CHK("data in", d, ram_pins_out.data_in)
      end
      if (rd_valid_out === 1'h1) begin
        vc = n;
        q = rd_data_out;
      end
      if (n > 40) begin
        mismatches++;
        end_sim();
      end
    end
    `CHK("select cycles", wr ? 4 : 8, lo)
    `CHK("ready cycle", wr ? 8 : 12, n)
    `CHK("answer cycle", wr ? 0 : 9, vc)
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_state();
    `CHK("idle select", SEL_N_RST, ram_pins_out.sel_n)
    `CHK("idle strobe", WR_N_RST, ram_pins_out.wr_strobe_n)
    `CHK("idle pulse", 1'h0, rd_valid_out)
    $display("Test reset_state done");
  endtask

  task automatic t_write_read();
    logic [ADDR_W-1:0] ad [3] = '{16'h0000, 16'hffff, 16'h1234};
    logic q;
    foreach (ad[i]) xfer(1'h1, ad[i], ~^ad[i], q);
    foreach (ad[i]) begin
      xfer(1'h0, ad[i], 1'h0, q);
      `CHK("read back", ~^ad[i], q)
    end
    xfer(1'h0, 16'h1233, 1'h0, q);
    `CHK("neighbour", ^16'h1233, q)
    $display("Test write_read done");
  endtask

  task automatic t_overwrite();
    logic q;
    for (int k = 0; k < 4; k++) begin
      xfer(1'h1, 16'h00ff, k[0], q);
      xfer(1'h0, 16'h00ff, 1'h0, q);
      `CHK("last write", k[0], q)
    end
    $display("Test overwrite done");
  endtask

  task automatic t_idle_hold();
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_sys_in); #1;
      `CHK("standby", 1'h1, ram_pins_out.sel_n)
      `CHK("held bit", 1'h1, rd_data_out)
    end
    $display("Test idle_hold done");
  endtask

  task automatic t_rereset();
    logic q;
    rstn_in = 1'h0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    `CHK("bit in reset", 1'h0, rd_data_out)
    rstn_in = 1'h1;
    t_reset_state();
    xfer(1'h0, 16'h00ff, 1'h0, q);
    `CHK("kept contents", 1'h1, q)
    $display("Test rereset done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1;
    rstn_in = 1'h1;
    t_reset_state();
    t_write_read();
    t_overwrite();
    t_idle_hold();
    t_rereset();
    end_sim();
  end
endmodule

/* tb/asrc_ram_model.sv */
// Behavioural 64K by 1 static RAM that answers the host controller
`timescale 1ns/1ps
module asrc_ram_model
  import asrc_pkg::*;
#(
  parameter int ACC_NS = 45  // Access time of the slowest grade
)(
  // Pins from the host
  input  wire asrc_pins_t pins_in,
  // Data output pin
  output logic            q_out
);
  logic              mem [DEPTH];
  logic              last_q;
  time               t_chg;
  wire logic         sel_n = pins_in.sel_n;
  wire logic         wr_n  = pins_in.wr_strobe_n;
  wire [ADDR_W-1:0]  a     = pins_in.location_select_lines;

  // ==========================================================
  // Storage, preset to address parity
  initial begin
    for (int i = 0; i < DEPTH; i++) mem[i] = ^i[ADDR_W-1:0];
    last_q = 1'h0;
    q_out  = 1'h1;
    t_chg  = 0;
  end

  // Level write while both low, last bit before release wins
  always @(pins_in) begin
    t_chg = $time;
    if (!sel_n && !wr_n) mem[a] = pins_in.data_in;
  end

  // ==========================================================
  // Output: valid only after access delay, otherwise a wrong level
  always #1 begin
    if (!sel_n && wr_n && ($time - t_chg >= ACC_NS)) begin
      q_out  = mem[a];
      last_q = mem[a];
    end else q_out = ~last_q;  // Floating or not yet valid
  end
endmodule
